// *** rtl/atp_top.sv ***
// Converter test-pattern generator with link test-mode selection.
// Assumes registers are written over the control port on clk, and that
// adc_valid pulses once per converter sample (the encode clock).
`timescale 1ns/1ps
module atp_top
    import atp_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              rst,
    input  wire logic              reg_wr_en,
    input  wire logic [ATP_AW-1:0] reg_addr,
    input  wire logic [7:0]        reg_wdata,
    output logic [7:0]             reg_rdata,
    input  wire logic              adc_valid,
    input  wire logic [ATP_W-1:0]  adc_a,
    input  wire logic [ATP_W-1:0]  adc_b,
    output logic                   adc_ready,
    output logic                   out_valid,
    input  wire logic              out_ready,
    output logic [ATP_W-1:0]       out_a,
    output logic [ATP_W-1:0]       out_b,
    output logic                   converter_disconnect,
    output logic [3:0]             dnc_i_pat_en,
    output logic [3:0]             dnc_q_pat_en,
    output logic                   transport_sample_test,
    output logic [3:0]             if_pattern_sel,
    output logic                   if_insert_sample,
    output logic                   if_insert_phy,
    output logic                   link_soft_reset
);
    localparam int NDNC  = 4;
    localparam int NUSER = 8;

    // Register storage
    logic [7:0] cfg0_reg;
    logic [7:0] conv_reg;
    logic [7:0] transport_reg;
    logic [7:0] iface_reg;
    logic [7:0] dnc_reg  [NDNC];
    logic [7:0] user_reg [NUSER];
    logic       soft_rst_reg;

    // Sequencer state
    logic             phase_reg;
    logic [1:0]       user_idx_reg;
    logic             user_done_reg;
    logic [ATP_W-1:0] ramp_reg;

    function automatic logic [ATP_AW-1:0] dnc_ofs(input int k);
        logic [ATP_AW-1:0] r;
        r = ATP_OFS_DNC0;
        case (k)
            1:       r = ATP_OFS_DNC1;
            2:       r = ATP_OFS_DNC2;
            3:       r = ATP_OFS_DNC3;
            default: r = ATP_OFS_DNC0;
        endcase
        return r;
    endfunction : dnc_ofs

    // Write decode
    logic wr_cfg0;
    logic wr_conv;
    logic wr_transport;
    logic wr_iface;
    logic soft_cmd;
    logic iface_blocked;
    assign wr_cfg0      = reg_wr_en && (reg_addr == ATP_OFS_SOFT_RESET);
    assign wr_conv      = reg_wr_en && (reg_addr == ATP_OFS_CONV);
    assign wr_transport = reg_wr_en && (reg_addr == ATP_OFS_TRANSPORT);
    assign wr_iface     = reg_wr_en && (reg_addr == ATP_OFS_IFACE);
    assign soft_cmd     = wr_cfg0 &&
                          ((reg_wdata & ATP_SOFT_RESET_CMD)
                           == ATP_SOFT_RESET_CMD);
    // Leaving an interface test mode is only possible through soft reset
    assign iface_blocked = (iface_reg != ATP_REG_RESET) &&
                           (reg_wdata == ATP_REG_RESET);

    // Soft-reset bits clear themselves one cycle after the write
    always_ff @(posedge clk) begin
        if (rst) begin
            cfg0_reg     <= ATP_REG_RESET;
            soft_rst_reg <= 1'b0;
        end else begin
            cfg0_reg     <= wr_cfg0 ? reg_wdata
                          : (cfg0_reg & ~ATP_SOFT_RESET_CMD);
            soft_rst_reg <= soft_cmd;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            conv_reg <= ATP_REG_RESET;
        end else if (wr_conv) begin
            conv_reg <= reg_wdata;
        end
    end

    // Link test registers return to normal on soft reset
    always_ff @(posedge clk) begin
        if (rst || soft_cmd) begin
            transport_reg <= ATP_REG_RESET;
            iface_reg     <= ATP_REG_RESET;
        end else begin
            if (wr_transport) begin
                transport_reg <= reg_wdata;
            end
            if (wr_iface && !iface_blocked) begin
                iface_reg <= reg_wdata;
            end
        end
    end

    for (genvar k = 0; k < NDNC; k++) begin : g_dnc
        always_ff @(posedge clk) begin
            if (rst) begin
                dnc_reg[k] <= ATP_REG_RESET;
            end else if (reg_wr_en && reg_addr == dnc_ofs(k)) begin
                dnc_reg[k] <= reg_wdata;
            end
        end
    end

    // User patterns: odd offset low byte, next offset high byte
    for (genvar u = 0; u < NUSER; u++) begin : g_user
        always_ff @(posedge clk) begin
            if (rst) begin
                user_reg[u] <= ATP_REG_RESET;
            end else if (reg_wr_en && reg_addr ==
                         ATP_OFS_USER_BASE + ATP_AW'(u)) begin
                user_reg[u] <= reg_wdata;
            end
        end
    end

    // Register read-back, registered to keep the port glitch free
    logic [7:0] rd_mux;
    logic       rd_user;
    logic [2:0] rd_user_idx;
    assign rd_user     = (reg_addr >= ATP_OFS_USER_BASE) &&
                         (reg_addr < ATP_OFS_USER_BASE + ATP_AW'(NUSER));
    assign rd_user_idx = 3'(reg_addr - ATP_OFS_USER_BASE);
    assign rd_mux = (reg_addr == ATP_OFS_SOFT_RESET) ? cfg0_reg
                  : (reg_addr == ATP_OFS_DNC0)       ? dnc_reg[0]
                  : (reg_addr == ATP_OFS_DNC1)       ? dnc_reg[1]
                  : (reg_addr == ATP_OFS_DNC2)       ? dnc_reg[2]
                  : (reg_addr == ATP_OFS_DNC3)       ? dnc_reg[3]
                  : (reg_addr == ATP_OFS_CONV)       ? conv_reg
                  : (reg_addr == ATP_OFS_TRANSPORT)  ? transport_reg
                  : (reg_addr == ATP_OFS_IFACE)      ? iface_reg
                  : rd_user ? user_reg[rd_user_idx]
                  : ATP_REG_RESET;

    always_ff @(posedge clk) begin
        if (rst) begin
            reg_rdata <= ATP_REG_RESET;
        end else begin
            reg_rdata <= rd_mux;
        end
    end

    // Mode decode and sample acceptance
    logic [3:0] mode;
    logic       active;
    logic       single;
    logic       fire;
    logic       restart;
    logic       pn_hold;
    logic       in_ready;
    assign mode    = conv_reg[ATP_SEL_LSB +: 4];
    assign active  = (mode != ATP_MODE_OFF);
    assign single  = conv_reg[ATP_USER_SINGLE];
    // No sample strobe, no advance: generation needs the encode clock
    assign fire    = adc_valid && in_ready;
    assign restart = wr_conv;
    assign pn_hold = conv_reg[ATP_PN_LONG_RST] ||
                     conv_reg[ATP_PN_SHORT_RST] || wr_conv;

    logic [ATP_W-1:0] pn_long_word;
    logic [ATP_W-1:0] pn_short_word;

    atp_pn_gen #(
        .LEN  (ATP_PN_LONG_LEN),
        .TAP  (ATP_PN_LONG_TAP),
        .SEED (ATP_PN_LONG_SEED),
        .W    (ATP_W)
    ) u_pn_long (
        .clk     (clk),
        .rst     (rst),
        .hold    (pn_hold),
        .advance (fire && mode == ATP_MODE_PN_LONG),
        .word    (pn_long_word)
    );

    atp_pn_gen #(
        .LEN  (ATP_PN_SHORT_LEN),
        .TAP  (ATP_PN_SHORT_TAP),
        .SEED (ATP_PN_SHORT_SEED),
        .W    (ATP_W)
    ) u_pn_short (
        .clk     (clk),
        .rst     (rst),
        .hold    (pn_hold),
        .advance (fire && mode == ATP_MODE_PN_SHORT),
        .word    (pn_short_word)
    );

    // Sequencers restart on any select write so each pattern opens clean
    always_ff @(posedge clk) begin
        if (rst || restart) begin
            phase_reg     <= 1'b0;
            user_idx_reg  <= 2'h0;
            user_done_reg <= 1'b0;
            ramp_reg      <= '0;
        end else if (fire) begin
            phase_reg     <= ~phase_reg;
            ramp_reg      <= ramp_reg + 14'h0001;
            user_idx_reg  <= user_idx_reg + 2'h1;
            if (user_idx_reg == 2'h3 && single) begin
                user_done_reg <= 1'b1;
            end
        end
    end

    // Current user word: bits 15..2 of the 16-bit pattern
    logic [15:0] user_pat;
    assign user_pat = {user_reg[{user_idx_reg, 1'b1}],
                       user_reg[{user_idx_reg, 1'b0}]};

    function automatic logic [ATP_W-1:0] pick(
        input logic [3:0]       m,
        input logic             ph,
        input logic             done,
        input logic [ATP_W-1:0] usr,
        input logic [ATP_W-1:0] pnl,
        input logic [ATP_W-1:0] pns,
        input logic [ATP_W-1:0] rmp
    );
        logic [ATP_W-1:0] w;
        w = ATP_WORD_ZERO;
        unique case (m)
            ATP_MODE_MID:      w = ATP_WORD_MID;
            ATP_MODE_POS:      w = ATP_WORD_POS;
            ATP_MODE_NEG:      w = ATP_WORD_NEG;
            ATP_MODE_CHECK:    w = ph ? ATP_WORD_CHECK1 : ATP_WORD_CHECK0;
            ATP_MODE_PN_LONG:  w = pnl;
            ATP_MODE_PN_SHORT: w = pns;
            ATP_MODE_TOGGLE:   w = ph ? ATP_WORD_TOGGLE1 : ATP_WORD_TOGGLE0;
            ATP_MODE_USER:     w = done ? ATP_WORD_ZERO : usr;
            ATP_MODE_RAMP:     w = rmp;
            default:           w = ATP_WORD_ZERO;
        endcase
        return w;
    endfunction : pick

    logic [ATP_W-1:0] gen_word;
    assign gen_word = pick(mode, phase_reg, user_done_reg,
                           user_pat[15:2], pn_long_word, pn_short_word,
                           ramp_reg);

    // Analog data is ignored whenever a pattern is selected
    logic [ATP_W-1:0] path_a;
    logic [ATP_W-1:0] path_b;
    assign path_a = active ? gen_word : adc_a;
    assign path_b = active ? gen_word : adc_b;

    atp_stream_if #(.W(2 * ATP_W)) s_in ();
    atp_stream_if #(.W(2 * ATP_W)) s_out ();

    assign s_in.valid  = adc_valid;
    assign s_in.data   = {path_a, path_b};
    assign in_ready    = s_in.ready;
    assign adc_ready   = s_in.ready;
    assign s_out.ready = out_ready;
    assign out_valid   = s_out.valid;
    assign out_a       = s_out.data[2*ATP_W-1:ATP_W];
    assign out_b       = s_out.data[ATP_W-1:0];

    atp_skid_buf #(
        .W     (2 * ATP_W),
        .DEPTH (2)
    ) u_buf (
        .clk   (clk),
        .rst   (rst),
        .in_s  (s_in),
        .out_s (s_out)
    );

    // Downconverter test steering: I takes channel A, Q takes channel B
    for (genvar k = 0; k < NDNC; k++) begin : g_dnc_en
        assign dnc_i_pat_en[k] = active &&
                                 dnc_reg[k][ATP_DNC_I_BIT];
        if (k == NDNC - 1) begin : g_last
            assign dnc_q_pat_en[k] = 1'b0;
        end else begin : g_other
            assign dnc_q_pat_en[k] = active &&
                                     dnc_reg[k][ATP_DNC_Q_BIT];
        end
    end

    // Link test selections
    assign converter_disconnect  = active;
    assign transport_sample_test =
               transport_reg[ATP_TRANSPORT_BIT];
    assign if_pattern_sel   = iface_reg[ATP_IF_PAT_LSB +: 4];
    assign if_insert_sample = (iface_reg[ATP_IF_INS_LSB +: 2]
                               == ATP_INS_SAMPLE);
    assign if_insert_phy    = (iface_reg[ATP_IF_INS_LSB +: 2]
                               == ATP_INS_PHY);
    assign link_soft_reset  = soft_rst_reg;

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    property p_fixed_word;
        (mode == ATP_MODE_POS) |-> (gen_word == ATP_WORD_POS);
    endproperty
    a_fixed_word: assert property (p_fixed_word)
        else $error("Full-scale word wrong");

    property p_path_pattern;
        (active && adc_valid) |-> (s_in.data == {gen_word, gen_word});
    endproperty
    a_path_pattern: assert property (p_path_pattern)
        else $error("Converter data leaked in test mode");

    property p_checker;
        (fire && !restart && mode == ATP_MODE_CHECK &&
         gen_word == ATP_WORD_CHECK0) |=> (gen_word == ATP_WORD_CHECK1);
    endproperty
    a_checker: assert property (p_checker)
        else $error("Checkerboard did not alternate");

    property p_toggle;
        (fire && !restart && mode == ATP_MODE_TOGGLE &&
         gen_word == ATP_WORD_TOGGLE1) |=> (gen_word == ATP_WORD_TOGGLE0);
    endproperty
    a_toggle: assert property (p_toggle)
        else $error("Word toggle did not alternate");

    property p_ramp;
        (fire && !restart && mode == ATP_MODE_RAMP) |=>
            (gen_word == ATP_W'($past(gen_word) + 14'h0001));
    endproperty
    a_ramp: assert property (p_ramp)
        else $error("Ramp step not one");

    property p_single_done;
        (mode == ATP_MODE_USER && single && !restart && fire &&
         user_idx_reg == 2'h3) |=> (gen_word == ATP_WORD_ZERO);
    endproperty
    a_single_done: assert property (p_single_done)
        else $error("Single user mode not zero after four");

    property p_soft_reset;
        soft_cmd |=> (iface_reg == ATP_REG_RESET && link_soft_reset)
                 ##1 (cfg0_reg[7] == 1'b0 || $past(wr_cfg0));
    endproperty
    a_soft_reset: assert property (p_soft_reset)
        else $error("Soft reset did not clear link test");

    property p_stall_holds;
        (!fire && !reg_wr_en && !pn_hold) |=> $stable(gen_word);
    endproperty
    a_stall_holds: assert property (p_stall_holds)
        else $error("Pattern moved without a sample");
endmodule : atp_top

// *** rtl/atp_pkg.sv ***
// Constants, register map and pattern encodings for the test-pattern block.
// Assumes one 200 MHz clock and registers written over the control port.
// Operation
// - Four-bit code picks the generated pattern
// - Any pattern replaces converter data downstream
// - Bit 4 or 5 resets PN generators
// - Patterns ignore analog input, need sample clock
// - Downconverter I carries A, Q carries B
// - Fourth downconverter: I only, bit 0 enables
// - Checkerboard alternates 0x1555 and 0x2AAA
// - Long PN: x^23+x^18+1, seed 0x3AFF
// - Short PN: x^9+x^5+1, seed 0x0092
// - Word toggle alternates 0x0000 and 0x3FFF
// - Repeat user mode cycles patterns one-four
// - Single user mode: four patterns, then zeros
// - Ramp increments by one, wraps at 2^14
// - Writing 0x81 to 0x00 returns link normal
// - Transport bit 5 enables raw sample test
// - Interface register: pattern [3:0], point [5:4]
// - Point 00 sample input, 01 PHY input
package atp_pkg;
    localparam int          ATP_W              = 14;
    localparam int          ATP_AW             = 12;
    // Register offsets
    localparam logic [11:0] ATP_OFS_SOFT_RESET = 12'h000;
    localparam logic [11:0] ATP_OFS_DNC0       = 12'h327;
    localparam logic [11:0] ATP_OFS_DNC1       = 12'h347;
    localparam logic [11:0] ATP_OFS_DNC2       = 12'h367;
    localparam logic [11:0] ATP_OFS_DNC3       = 12'h387;
    localparam logic [11:0] ATP_OFS_CONV       = 12'h550;
    localparam logic [11:0] ATP_OFS_USER_BASE  = 12'h551;
    localparam logic [11:0] ATP_OFS_TRANSPORT  = 12'h571;
    localparam logic [11:0] ATP_OFS_IFACE      = 12'h573;
    localparam logic [7:0]  ATP_REG_RESET      = 8'h00;
    localparam logic [7:0]  ATP_SOFT_RESET_CMD = 8'h81;
    // Field positions
    localparam int          ATP_SEL_LSB        = 0;
    localparam int          ATP_PN_LONG_RST    = 4;
    localparam int          ATP_PN_SHORT_RST   = 5;
    localparam int          ATP_USER_SINGLE    = 7;
    localparam int          ATP_DNC_I_BIT      = 0;
    localparam int          ATP_DNC_Q_BIT      = 2;
    localparam int          ATP_TRANSPORT_BIT  = 5;
    localparam int          ATP_IF_PAT_LSB     = 0;
    localparam int          ATP_IF_INS_LSB     = 4;
    // Pattern select codes
    localparam logic [3:0]  ATP_MODE_OFF       = 4'h0;
    localparam logic [3:0]  ATP_MODE_MID       = 4'h1;
    localparam logic [3:0]  ATP_MODE_POS       = 4'h2;
    localparam logic [3:0]  ATP_MODE_NEG       = 4'h3;
    localparam logic [3:0]  ATP_MODE_CHECK     = 4'h4;
    localparam logic [3:0]  ATP_MODE_PN_LONG   = 4'h5;
    localparam logic [3:0]  ATP_MODE_PN_SHORT  = 4'h6;
    localparam logic [3:0]  ATP_MODE_TOGGLE    = 4'h7;
    localparam logic [3:0]  ATP_MODE_USER      = 4'h8;
    localparam logic [3:0]  ATP_MODE_RAMP      = 4'hF;
    // Fixed words
    localparam logic [13:0] ATP_WORD_MID       = 14'h0000;
    localparam logic [13:0] ATP_WORD_POS       = 14'h1FFF;
    localparam logic [13:0] ATP_WORD_NEG       = 14'h2000;
    localparam logic [13:0] ATP_WORD_CHECK0    = 14'h1555;
    localparam logic [13:0] ATP_WORD_CHECK1    = 14'h2AAA;
    localparam logic [13:0] ATP_WORD_TOGGLE0   = 14'h0000;
    localparam logic [13:0] ATP_WORD_TOGGLE1   = 14'h3FFF;
    localparam logic [13:0] ATP_WORD_ZERO      = 14'h0000;
    // PN generators
    localparam int          ATP_PN_LONG_LEN    = 23;
    localparam int          ATP_PN_LONG_TAP    = 18;
    localparam logic [31:0] ATP_PN_LONG_SEED   = 32'h0000_3AFF;
    localparam int          ATP_PN_SHORT_LEN   = 9;
    localparam int          ATP_PN_SHORT_TAP   = 5;
    localparam logic [31:0] ATP_PN_SHORT_SEED  = 32'h0000_0092;
    // Interface insertion points
    localparam logic [1:0]  ATP_INS_SAMPLE     = 2'h0;
    localparam logic [1:0]  ATP_INS_PHY        = 2'h1;
endpackage : atp_pkg

// *** rtl/atp_stream_if.sv ***
// Valid/ready word stream between the pattern logic and its buffer.
// Assumes both ends share one clock.
`timescale 1ns/1ps
interface atp_stream_if #(parameter int W = 28);
    logic         valid;
    logic         ready;
    logic [W-1:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface : atp_stream_if

// *** rtl/atp_pn_gen.sv ***
// Fibonacci LFSR that yields W fresh bits per advance, MSB first.
// Assumes hold and advance are synchronous single-clock controls.
`timescale 1ns/1ps
module atp_pn_gen
    import atp_pkg::*;
#(
    parameter int          LEN  = ATP_PN_SHORT_LEN,
    parameter int          TAP  = ATP_PN_SHORT_TAP,
    parameter logic [31:0] SEED = ATP_PN_SHORT_SEED,
    parameter int          W    = ATP_W
) (
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire logic         hold,
    input  wire logic         advance,
    output logic [W-1:0]      word
);
    if (LEN > 32 || TAP >= LEN || TAP < 1 || W < 1) begin : g_chk
        $error("atp_pn_gen: unsupported LEN/TAP/W");
    end

    logic [LEN-1:0] state_reg;
    logic [LEN-1:0] state_next;
    logic [W-1:0]   word_next;

    // Unroll W shifts so the word is ready before the sample is taken
    always_comb begin
        state_next = state_reg;
        word_next  = '0;
        for (int i = 0; i < W; i++) begin
            word_next  = {word_next[W-2:0], state_next[0]};
            state_next = {state_next[0] ^ state_next[LEN-TAP],
                          state_next[LEN-1:1]};
        end
    end

    assign word = word_next;

    // Hold forces the seed back so the sequence restarts cleanly
    always_ff @(posedge clk) begin
        if (rst || hold) begin
            state_reg <= SEED[LEN-1:0];
        end else if (advance) begin
            state_reg <= state_next;
        end
    end

    property p_pn_hold;
        @(posedge clk) disable iff (rst)
        hold |=> (state_reg == SEED[LEN-1:0]);
    endproperty
    a_pn_hold: assert property (p_pn_hold)
        else $error("PN state not reseeded after hold");
endmodule : atp_pn_gen

// *** rtl/atp_skid_buf.sv ***
// Two-entry buffer; a receiver stall backs up into the sample source.
// Assumes a single clock; entries are flip-flops indexed by pointer.
`timescale 1ns/1ps
module atp_skid_buf #(
    parameter int W     = 28,
    parameter int DEPTH = 2
) (
    input  wire logic clk,
    input  wire logic rst,
    atp_stream_if.snk in_s,
    atp_stream_if.src out_s
);
    if (DEPTH != 2 || W < 1) begin : g_chk
        $error("atp_skid_buf: only two entries supported");
    end

    logic [W-1:0] mem_reg [DEPTH];
    logic         wr_ptr_reg;
    logic         rd_ptr_reg;
    logic [1:0]   count_reg;
    logic         push;
    logic         pop;

    // Honest full and empty from the occupancy count
    assign in_s.ready  = (count_reg != 2'h2);
    assign out_s.valid = (count_reg != 2'h0);
    assign out_s.data  = mem_reg[rd_ptr_reg];
    assign push        = in_s.valid && in_s.ready;
    assign pop         = out_s.valid && out_s.ready;

    always_ff @(posedge clk) begin
        if (push) begin
            mem_reg[wr_ptr_reg] <= in_s.data;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            wr_ptr_reg <= 1'b0;
            rd_ptr_reg <= 1'b0;
            count_reg  <= 2'h0;
        end else begin
            wr_ptr_reg <= wr_ptr_reg ^ push;
            rd_ptr_reg <= rd_ptr_reg ^ pop;
            count_reg  <= count_reg + {1'b0, push} - {1'b0, pop};
        end
    end

    property p_full_refuses;
        @(posedge clk) disable iff (rst)
        (count_reg == 2'h2 && !pop) |=> !in_s.ready;
    endproperty
    a_full_refuses: assert property (p_full_refuses)
        else $error("Buffer accepted a word while full");
endmodule : atp_skid_buf

// *** tb/atp_sink_model.sv ***
// Downstream formatter stand-in: takes pattern words, may stall.
// Assumes the bench drives stall away from the rising edge.
`timescale 1ns/1ps
module atp_sink_model (
    input  wire logic        clk,
    input  wire logic        stall,
    input  wire logic        out_valid,
    input  wire logic [27:0] word,
    output logic             out_ready,
    output logic [27:0]      last_word
);
    // Ready drops only while stalled; no word is taken then
    assign out_ready = !stall;
    // Keep the last word taken so the bench can compare it
    always @(posedge clk) begin
        if (out_valid && out_ready) begin
            last_word <= word;
        end
    end
endmodule : atp_sink_model

// *** tb/atp_top_tb.sv ***
// Self-checking bench for the converter test-pattern block.
// Assumes a 200 MHz clock; inputs change on the falling edge.
`timescale 1ns/1ps
module atp_top_tb;
    import atp_pkg::*;
    logic        clk, rst, wen, adc_valid, stall, adc_ready, out_valid;
    logic        out_ready, disc, tst, ins_s, ins_p, srst;
    logic [11:0] addr;
    logic [7:0]  wd, rdat;
    logic [13:0] oa, ob;
    logic [3:0]  di, dq, psel;
    logic [27:0] lw;
    int          bad_count, num_checks;
    // Analog inputs carry fixed junk that test words must ignore
    atp_top atp_top_i (.clk(clk), .rst(rst), .reg_wr_en(wen),
        .reg_addr(addr), .reg_wdata(wd), .reg_rdata(rdat),
        .adc_valid(adc_valid), .adc_a(14'h0ABC), .adc_b(14'h1234),
        .adc_ready(adc_ready), .out_valid(out_valid),
        .out_ready(out_ready), .out_a(oa), .out_b(ob),
        .converter_disconnect(disc), .dnc_i_pat_en(di),
        .dnc_q_pat_en(dq), .transport_sample_test(tst),
        .if_pattern_sel(psel), .if_insert_sample(ins_s),
        .if_insert_phy(ins_p), .link_soft_reset(srst));
    atp_sink_model atp_sink_model_i (.clk(clk), .stall(stall),
        .out_valid(out_valid), .word({oa, ob}), .out_ready(out_ready),
        .last_word(lw));
    task automatic chk(input logic [27:0] g, input logic [27:0] e);
        num_checks++;
        if (g !== e) begin
            bad_count++;
            $display("[ERR] %0t got %h exp %h", $time, g, e);
        end
    endtask : chk
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        @(negedge clk);
        wen = 1;
        addr = a;
        wd = d;
        @(negedge clk);
        wen = 0;
    endtask : wr
    task automatic rd(input logic [11:0] a, input logic [7:0] e);
        @(negedge clk);
        addr = a;
        @(negedge clk);
        chk(28'(rdat), 28'(e));
    endtask : rd
    // One sample in; the receiver takes it one edge later
    task automatic smp(input logic [27:0] e);
        @(negedge clk);
        adc_valid = 1;
        @(negedge clk);
        adc_valid = 0;
        @(negedge clk);
        chk(lw, e);
    endtask : smp
    function automatic logic [13:0] ex(input logic [3:0] m, input int i);
        logic [15:0] u;
        logic [69:0] pl;
        logic [69:0] ps;
        u = {8'(8'h13 * (2 * (i % 4) + 2)), 8'(8'h13 * (2 * (i % 4) + 1))};
        // First five words of each generator, oldest in the low bits
        pl = {14'h1CA6, 14'h0A3D, 14'h26E0, 14'h0002, 14'h3FD7};
        ps = {14'h0697, 14'h0C65, 14'h2660, 14'h3C9A, 14'h125B};
        case (m)
            ATP_MODE_MID:      return ATP_WORD_MID;
            ATP_MODE_POS:      return ATP_WORD_POS;
            ATP_MODE_NEG:      return ATP_WORD_NEG;
            ATP_MODE_CHECK:    return i[0] ? 14'h2AAA : 14'h1555;
            ATP_MODE_PN_LONG:  return pl[14 * i +: 14];
            ATP_MODE_PN_SHORT: return ps[14 * i +: 14];
            ATP_MODE_TOGGLE:   return i[0] ? 14'h3FFF : 14'h0000;
            ATP_MODE_USER:     return u[15:2];
            ATP_MODE_RAMP:     return 14'(i);
            ATP_MODE_OFF:      return (i > 3) ? 14'h0000 : u[15:2];
            default:           return 14'h0000;
        endcase
    endfunction : ex
    task automatic finish_test;
        $display("checks %0d errors %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : finish_test
    initial begin
        clk = 0;
        forever #2.5 clk = ~clk;
    end
    // Whole run is under 1500 cycles; four times that means a hang
    initial begin
        #30000;
        bad_count++;
        finish_test;
    end
    initial begin
        {rst, wen, adc_valid, stall, addr, wd} = {4'h8, 20'h0};
        repeat (5) @(posedge clk);
        @(negedge clk);
        rst = 0;
        rd(ATP_OFS_CONV, 8'h00);
        rd(12'h123, 8'h00);
        smp({14'h0ABC, 14'h1234});
        chk(28'(disc), 28'h0);
        for (int k = 0; k < 8; k++)
            wr(ATP_OFS_USER_BASE + 12'(k), 8'(19 * k + 19));
        // Code 16 wraps to 0 in ex and stands for single-shot user mode
        for (int m = 1; m < 17; m++) begin
            wr(ATP_OFS_CONV, (m == 16) ? 8'h88 : 8'(m));
            for (int i = 0; i < 5; i++) smp({2{ex(4'(m), i)}});
        end
        // Reset bit held: the long generator stays on its seed word
        wr(ATP_OFS_CONV, 8'h15);
        smp({2{14'h3FD7}});
        smp({2{14'h3FD7}});
        chk(28'(disc), 28'h1);
        wr(ATP_OFS_DNC0, 8'h05);
        wr(ATP_OFS_DNC3, 8'h05);
        rd(ATP_OFS_DNC0, 8'h05);
        chk(28'({di, dq}), 28'h91);
        wr(ATP_OFS_CONV, 8'h0F);
        stall = 1;
        adc_valid = 1;
        repeat (3) @(negedge clk);
        chk(28'({adc_ready, out_valid}), 28'h1);
        adc_valid = 0;
        stall = 0;
        repeat (2) @(negedge clk);
        chk(lw, 28'h0004001);
        smp({2{14'h0002}});
        // Interface test goes on; a zero write must not leave it, only soft reset
        wr(ATP_OFS_IFACE, 8'h12);
        chk(28'({psel, ins_s, ins_p}), 28'h09);
        wr(ATP_OFS_IFACE, 8'h00);
        wr(ATP_OFS_TRANSPORT, 8'h20);
        chk(28'({psel, tst}), 28'h5);
        wr(ATP_OFS_SOFT_RESET, ATP_SOFT_RESET_CMD);
        chk(28'(srst), 28'h1);
        rd(ATP_OFS_IFACE, 8'h00);
        chk(28'({tst, ins_s, srst}), 28'h2);
        finish_test;
    end
endmodule : atp_top_tb
